// *** design/isp_pkg.sv ***
// Constants, carriers and states of the serial programming port
package isp_pkg;

  // ==========================================================================
  // Clock rates and link phase limits
  localparam int SYS_MHZ = 100;
  localparam int CPU_HZ = SYS_MHZ * 1000000;
  localparam int SCK_FAST_HZ = 12000000;
  localparam int SCK_PHASE_SLOW_CYC = 3; // Strictly more than two cycles
  localparam int SCK_PHASE_FAST_CYC = 3;
  localparam int SCK_PHASE_MIN_CYC =
    (CPU_HZ >= SCK_FAST_HZ) ? SCK_PHASE_FAST_CYC : SCK_PHASE_SLOW_CYC;
  // Sync of the request toggle plus one register stage for the answer
  localparam int RESP_LAT_CYC = 5;
  localparam int SCK_HIGH_MIN_CYC =
    (RESP_LAT_CYC + 1 > SCK_PHASE_MIN_CYC) ? RESP_LAT_CYC + 1 : SCK_PHASE_MIN_CYC;

  // ==========================================================================
  // Self-timed write delays
  localparam real T_FLASH_MS = 4.5;
  localparam real T_EE_MS = 9.0;
  localparam real T_FUSE_MS = 4.5;
  localparam real T_ERASE_MS = 9.0;
  localparam int FLASH_WAIT_CYC = int'($ceil(T_FLASH_MS * 1000.0 * SYS_MHZ));
  localparam int EE_WAIT_CYC = int'($ceil(T_EE_MS * 1000.0 * SYS_MHZ));
  localparam int FUSE_WAIT_CYC = int'($ceil(T_FUSE_MS * 1000.0 * SYS_MHZ));
  localparam int ERASE_WAIT_CYC = int'($ceil(T_ERASE_MS * 1000.0 * SYS_MHZ));
  localparam int WAIT_W = 20;

  // ==========================================================================
  // Memory geometry
  localparam int FL_AW = 14;
  localparam int FL_WORDS = 16384;
  localparam int PG_AW = 6;
  localparam int PG_WORDS = 64;
  localparam int EE_AW = 10;
  localparam int EE_BYTES = 1024;
  localparam int LOCK_W = 6;
  localparam logic [FL_AW-1:0] ERASE_LAST = 14'h3FFF;
  localparam logic [FL_AW-1:0] PAGE_LAST = 14'h003F;

  // ==========================================================================
  // Frame bit counter marks (count of rising edges already seen)
  localparam logic [4:0] CNT_B1_END = 5'h07;
  localparam logic [4:0] CNT_B2_END = 5'h0F;
  localparam logic [4:0] CNT_B3_END = 5'h17;
  localparam logic [4:0] CNT_B4_START = 5'h18;
  localparam logic [4:0] CNT_B4_END = 5'h1F;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam int HSEL_BIT = 3;

  // ==========================================================================
  // Instruction codes
  localparam logic [7:0] OP_ENABLE = 8'hAC;
  localparam logic [7:0] OP_ENABLE2 = 8'h53;
  localparam logic [7:0] OP_RD_FL = 8'h20;
  localparam logic [7:0] OP_RD_FL_H = 8'h28;
  localparam logic [7:0] OP_LD_PG = 8'h40;
  localparam logic [7:0] OP_LD_PG_H = 8'h48;
  localparam logic [7:0] OP_WR_PG = 8'h4C;
  localparam logic [7:0] OP_RD_EE = 8'hA0;
  localparam logic [7:0] OP_WR_EE = 8'hC0;
  localparam logic [7:0] OP_RD_LOCK = 8'h58;
  localparam logic [7:0] OP_RD_FUSE = 8'h50;
  localparam logic [7:0] OP_RD_SIG = 8'h30;
  localparam logic [7:0] OP_RD_CAL = 8'h38;
  localparam logic [2:0] SUB_ERASE = 3'h4;
  localparam logic [2:0] SUB_LOCK = 3'h7;
  localparam logic [7:0] SUB_FUSE_LO = 8'hA0;
  localparam logic [7:0] SUB_FUSE_HI = 8'hA8;
  localparam logic [7:0] SUB_RD_HI = 8'h08;

  // ==========================================================================
  // Erased and padding values
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [LOCK_W-1:0] LOCK_ERASED = 6'h3F;
  localparam logic [1:0] LOCK_PAD = 2'h3;

  // ==========================================================================
  // Carriers and states
  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
  } cmd_t;

  typedef enum logic {ST_IDLE, ST_BUSY} state_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] sh;
    logic [7:0] last;
    cmd_t hold;
    logic [7:0] data;
  } link_t;

  typedef struct packed {
    logic rd_tog;
    logic ex_tog;
  } tog_t;

  typedef struct packed {
    logic [7:0] sr;
    logic miso;
  } out_t;

  typedef struct packed {
    logic [2:0] rs;
    logic [2:0] rdq;
    logic [2:0] exq;
    logic rd_seen;
    logic ex_seen;
    logic pin_lo;
    logic enabled;
    logic busy;
    state_t state;
    logic erasing;
    logic paging;
    logic ee_busy;
    logic walk_act;
    logic [FL_AW-1:0] walk;
    logic [FL_AW-1:0] walk_last;
    logic [WAIT_W-1:0] wait_cnt;
    logic [WAIT_W-1:0] wait_lim;
    logic [7:0] page;
    logic [EE_AW-1:0] ee_addr;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [LOCK_W-1:0] lock;
    logic [7:0] resp;
  } sys_t;

endpackage

// *** design/isp_port.sv ***
// Serial in-system programming port with its memories
`timescale 1ns/100ps
`default_nettype none

module isp_port #(
  parameter int FLASH_WAIT = isp_pkg::FLASH_WAIT_CYC,
  parameter int EE_WAIT = isp_pkg::EE_WAIT_CYC,
  parameter int FUSE_WAIT = isp_pkg::FUSE_WAIT_CYC,
  parameter int ERASE_WAIT = isp_pkg::ERASE_WAIT_CYC,
  parameter logic [7:0] FUSE_LO_INIT = 8'hFF,
  parameter logic [7:0] FUSE_HI_INIT = 8'hFF,
  parameter logic [7:0] SIG0 = 8'h11, // Arbitrary identity value
  parameter logic [7:0] SIG1 = 8'h22, // Arbitrary identity value
  parameter logic [7:0] SIG2 = 8'h33, // Arbitrary identity value
  parameter logic [7:0] CAL0 = 8'h80,
  parameter logic [7:0] CAL1 = 8'h81,
  parameter logic [7:0] CAL2 = 8'h82,
  parameter logic [7:0] CAL3 = 8'h83
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic target_reset_n,
  output var logic miso,
  output var logic prog_enabled,
  output var logic prog_busy
);
  import isp_pkg::*;

  // ==========================================================================
  // State, next state and memories
  link_t l, next_l;
  tog_t tg, next_tg;
  out_t o, next_o;
  sys_t s, next_s;
  logic link_rst_n, fl_we, ee_we, pbl_we, pbh_we, pg_hit, rd_ev, ex_ev, go;
  logic [7:0] byte_in, out_src, ee_wd, pb_wd, ee_rd, rd_byte;
  logic [15:0] flash [FL_WORDS];
  logic [7:0] eeprom [EE_BYTES];
  logic [7:0] pb_lo [PG_WORDS], pb_hi [PG_WORDS];
  logic [FL_AW-1:0] fl_addr;
  logic [15:0] fl_wd, fl_rd;
  logic [EE_AW-1:0] ee_wa, ee_ra;
  logic [PG_AW-1:0] pb_idx;
  logic [WAIT_W-1:0] go_lim;

  // Link logic lives only while the target reset pin is held low
  assign link_rst_n = rst_n & ~target_reset_n;
  assign byte_in = {l.sh[6:0], mosi};

  // ==========================================================================
  // Link side: shift in on rising SCK, frame into four bytes
  always_comb begin
    next_l = l;
    next_tg = tg;
    next_l.sh = byte_in;
    next_l.cnt = l.cnt + 1'b1;
    if (l.cnt[2:0] == BIT_LAST) begin
      next_l.last = byte_in;
    end
    // Hold bytes stay put long after each toggle, so words cross safely
    case (l.cnt)
      CNT_B1_END: next_l.hold.b1 = byte_in;
      CNT_B2_END: next_l.hold.b2 = byte_in;
      CNT_B3_END: begin
        next_l.hold.b3 = byte_in;
        next_tg.rd_tog = ~tg.rd_tog;
      end
      CNT_B4_END: begin
        next_l.data = byte_in;
        next_tg.ex_tog = ~tg.ex_tog;
      end
      default: ;
    endcase
  end

  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // Toggles survive reset pulses, so the far side never sees a false event
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      tg <= '0;
    end else begin
      tg <= next_tg;
    end
  end

  // ==========================================================================
  // Link side: drive MISO on falling SCK
  always_comb begin
    next_o = o;
    out_src = l.last;
    // Answer must be ready within one SCK high phase after byte 3
    if (l.cnt == CNT_B4_START) begin
      out_src = s.resp;
    end
    if (l.cnt[2:0] == BIT_FIRST) begin
      next_o.miso = out_src[7];
      next_o.sr = {out_src[6:0], 1'b0};
    end else begin
      next_o.miso = o.sr[7];
      next_o.sr = {o.sr[6:0], 1'b0};
    end
  end

  always_ff @(negedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  // ==========================================================================
  // System side: sync, decode, execute and time writes
  always_comb begin
    next_s = s;
    fl_we = 1'b0;
    fl_addr = '0;
    fl_wd = '0;
    ee_we = 1'b0;
    ee_wa = '0;
    ee_wd = '0;
    pbl_we = 1'b0;
    pbh_we = 1'b0;
    pb_idx = '0;
    pb_wd = '0;
    go = 1'b0;
    go_lim = '0;
    next_s.rs = {s.rs[1:0], target_reset_n};
    next_s.rdq = {s.rdq[1:0], tg.rd_tog};
    next_s.exq = {s.exq[1:0], tg.ex_tog};
    if (s.rs[1] == s.rs[2]) begin
      next_s.pin_lo = ~s.rs[2];
    end
    rd_ev = (s.rdq[1] == s.rdq[2]) && (s.rdq[2] != s.rd_seen);
    ex_ev = (s.exq[1] == s.exq[2]) && (s.exq[2] != s.ex_seen);
    if (rd_ev) begin
      next_s.rd_seen = s.rdq[2];
    end
    if (ex_ev) begin
      next_s.ex_seen = s.exq[2];
    end
    // Leaving reset drops programming mode
    if (!s.pin_lo) begin
      next_s.enabled = 1'b0;
    end
    // Read answer for byte 4; default echoes byte 3
    fl_rd = flash[{l.hold.b2[5:0], l.hold.b3}];
    ee_ra = {l.hold.b2[1:0], l.hold.b3};
    ee_rd = eeprom[ee_ra];
    pg_hit = s.paging && ({l.hold.b2[5:0], l.hold.b3[7:6]} == s.page);
    rd_byte = l.hold.b3;
    if (s.enabled) begin
      case (l.hold.b1)
        OP_RD_FL, OP_RD_FL_H: begin
          if (pg_hit) begin
            rd_byte = ERASED_BYTE;
          end else begin
            rd_byte = l.hold.b1[HSEL_BIT] ? fl_rd[15:8] : fl_rd[7:0];
          end
        end
        OP_RD_EE: begin
          if (s.ee_busy && ee_ra == s.ee_addr) begin
            rd_byte = ERASED_BYTE;
          end else begin
            rd_byte = ee_rd;
          end
        end
        OP_RD_FUSE: rd_byte = s.fuse_lo;
        OP_RD_LOCK: begin
          if (l.hold.b2 == SUB_RD_HI) begin
            rd_byte = s.fuse_hi;
          end else begin
            rd_byte = {LOCK_PAD, s.lock};
          end
        end
        OP_RD_SIG: begin
          case (l.hold.b3[1:0])
            2'h0: rd_byte = SIG0;
            2'h1: rd_byte = SIG1;
            2'h2: rd_byte = SIG2;
            default: rd_byte = ERASED_BYTE;
          endcase
        end
        OP_RD_CAL: begin
          case (l.hold.b3[7:6])
            2'h0: rd_byte = CAL0;
            2'h1: rd_byte = CAL1;
            2'h2: rd_byte = CAL2;
            default: rd_byte = CAL3;
          endcase
        end
        default: ;
      endcase
    end
    if (rd_ev) begin
      next_s.resp = rd_byte;
    end
    // Whole frame in; writes are dropped while busy or not enabled
    if (ex_ev && s.pin_lo) begin
      if (l.hold.b1 == OP_ENABLE && l.hold.b2 == OP_ENABLE2) begin
        next_s.enabled = 1'b1;
      end else if (s.enabled && s.state == ST_IDLE) begin
        case (l.hold.b1)
          OP_LD_PG, OP_LD_PG_H: begin
            pb_idx = l.hold.b3[PG_AW-1:0];
            pb_wd = l.data;
            pbl_we = ~l.hold.b1[HSEL_BIT];
            pbh_we = l.hold.b1[HSEL_BIT];
          end
          OP_WR_PG: begin
            next_s.paging = 1'b1;
            next_s.page = {l.hold.b2[5:0], l.hold.b3[7:6]};
            next_s.walk = '0;
            next_s.walk_last = PAGE_LAST;
            next_s.walk_act = 1'b1;
            go = 1'b1;
            go_lim = WAIT_W'(FLASH_WAIT - 1);
          end
          OP_WR_EE: begin
            ee_we = 1'b1;
            ee_wa = ee_ra;
            ee_wd = l.data;
            next_s.ee_busy = 1'b1;
            next_s.ee_addr = ee_ra;
            go = 1'b1;
            go_lim = WAIT_W'(EE_WAIT - 1);
          end
          OP_ENABLE: begin
            if (l.hold.b2[7:5] == SUB_ERASE) begin
              next_s.erasing = 1'b1;
              next_s.lock = LOCK_ERASED;
              next_s.walk = '0;
              next_s.walk_last = ERASE_LAST;
              next_s.walk_act = 1'b1;
              go = 1'b1;
              go_lim = WAIT_W'(ERASE_WAIT - 1);
            end else if (l.hold.b2[7:5] == SUB_LOCK) begin
              next_s.lock = s.lock & l.data[LOCK_W-1:0];
              go = 1'b1;
              go_lim = WAIT_W'(FUSE_WAIT - 1);
            end else if (l.hold.b2 == SUB_FUSE_LO) begin
              next_s.fuse_lo = l.data;
              go = 1'b1;
              go_lim = WAIT_W'(FUSE_WAIT - 1);
            end else if (l.hold.b2 == SUB_FUSE_HI) begin
              next_s.fuse_hi = l.data;
              go = 1'b1;
              go_lim = WAIT_W'(FUSE_WAIT - 1);
            end
          end
          default: ;
        endcase
      end
    end
    if (go) begin
      next_s.state = ST_BUSY;
      next_s.busy = 1'b1;
      next_s.wait_cnt = '0;
      next_s.wait_lim = go_lim;
    end
    // Busy: walk the memory first, then finish out the write time
    case (s.state)
      ST_BUSY: begin
        next_s.wait_cnt = s.wait_cnt + 1'b1;
        if (s.walk_act) begin
          fl_we = 1'b1;
          if (s.erasing) begin
            fl_addr = s.walk;
            fl_wd = ERASED_WORD;
            ee_we = 1'b1;
            ee_wa = s.walk[EE_AW-1:0];
            ee_wd = ERASED_BYTE;
          end else begin
            pb_idx = s.walk[PG_AW-1:0];
            fl_addr = {s.page, pb_idx};
            fl_wd = {pb_hi[pb_idx], pb_lo[pb_idx]};
            pb_wd = ERASED_BYTE;
            pbl_we = 1'b1;
            pbh_we = 1'b1;
          end
          next_s.walk = s.walk + 1'b1;
          if (s.walk == s.walk_last) begin
            next_s.walk_act = 1'b0;
          end
        end else if (s.wait_cnt >= s.wait_lim) begin
          next_s.state = ST_IDLE;
          next_s.busy = 1'b0;
          next_s.erasing = 1'b0;
          next_s.paging = 1'b0;
          next_s.ee_busy = 1'b0;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.fuse_lo <= FUSE_LO_INIT;
      s.fuse_hi <= FUSE_HI_INIT;
      s.lock <= LOCK_ERASED;
    end else begin
      s <= next_s;
    end
  end

  // Memories keep no reset, as non-volatile cells would
  always_ff @(posedge sys_clk) begin
    if (fl_we) begin
      flash[fl_addr] <= fl_wd;
    end
    if (ee_we) begin
      eeprom[ee_wa] <= ee_wd;
    end
    if (pbl_we) begin
      pb_lo[pb_idx] <= pb_wd;
    end
    if (pbh_we) begin
      pb_hi[pb_idx] <= pb_wd;
    end
  end

  // ==========================================================================
  // Outputs
  assign miso = o.miso;
  assign prog_enabled = s.enabled;
  assign prog_busy = s.busy;

endmodule
`default_nettype wire

// *** verif/isp_port_chk.sv ***
// Concurrent checks on the pins of the serial programming port
`timescale 1ns/100ps
`default_nettype none
module isp_port_chk #(
  parameter int ERASE_WAIT = 100
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic target_reset_n,
  input wire logic miso,
  input wire logic prog_enabled,
  input wire logic prog_busy
);
  // ==========================================================================
  // Helper logic
  // Longest self-timed job is the erase walk over every Flash word
  localparam int BUSY_MAX = ((ERASE_WAIT > 16385) ? ERASE_WAIT : 16385) + 2;
  int busy_cnt;
  logic [4:0] cnt;
  logic [7:0] hist;
  // Busy run length in system cycles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= prog_busy ? busy_cnt + 1 : 0;
    end
  end
  // Own view of link framing; a reset pin pulse restarts it
  always_ff @(posedge sck or posedge target_reset_n or negedge rst_n) begin
    if (target_reset_n || !rst_n) begin
      cnt <= 5'h00;
      hist <= 8'h00;
    end else begin
      cnt <= cnt + 5'h01;
      hist <= {hist[6:0], mosi};
    end
  end
  // ==========================================================================
  // Assertions
  miso_on_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(miso) && target_reset_n == 1'b0 && $past(target_reset_n) == 1'b0
    |-> !sck && $past(sck)) else $error("miso moved away from a falling sck");
  miso_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    target_reset_n && $past(target_reset_n) |-> !miso) else $error("miso not idle in reset");
  echo_byte_a: assert property (@(posedge sck) disable iff (target_reset_n || !rst_n)
    cnt >= 5'h08 && cnt <= 5'h17 |-> miso == hist[7]) else $error("byte echo wrong");
  enable_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(target_reset_n) |-> ##[1:6] !prog_enabled) else $error("enable kept after reset pin");
  enable_rise_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(prog_enabled) |-> !target_reset_n) else $error("enable rose with reset pin high");
  enable_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!target_reset_n) [*8] |-> ##1 !$fell(prog_enabled)) else $error("enable lost in session");
  busy_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(prog_busy) |-> prog_enabled) else $error("write started while not enabled");
  busy_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busy_cnt <= BUSY_MAX) else $error("busy lasted too long");
endmodule
bind isp_port isp_port_chk #(.ERASE_WAIT(ERASE_WAIT)) i_isp_port_chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .sck(sck),
  .mosi(mosi),
  .target_reset_n(target_reset_n),
  .miso(miso),
  .prog_enabled(prog_enabled),
  .prog_busy(prog_busy)
);
`default_nettype wire

// *** verif/isp_prog_model.sv ***
// Behavioural model of the external programmer driving the link
`timescale 1ns/100ps
`default_nettype none
module isp_prog_model (
  input wire logic link_clk,
  output var logic sck,
  output var logic mosi,
  output var logic target_reset_n,
  input wire logic miso
);
  // ==========================================================================
  // Power-up: reset pin and sck both low
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    target_reset_n = 1'b0;
  end
  // Four link ticks per phase keeps each sck phase at 60 ns
  task automatic half();
    repeat (4) @(posedge link_clk);
  endtask
  // Shift n bits of f MSB first; sample miso on rising sck
  task automatic xfer(input logic [31:0] f, input int n, output logic [31:0] q);
    q = 32'h0;
    @(posedge link_clk);
    for (int i = 31; i >= 32 - n; i--) begin
      mosi <= f[i];
      half();
      sck <= 1'b1;
      q[i] = miso;
      half();
      sck <= 1'b0;
    end
    // Released line shows the inverse so a stale bit never passes
    mosi <= ~f[32 - n];
  endtask
  // Retry path: reset pin pulsed high with sck held low
  task automatic pulse_reset();
    @(posedge link_clk);
    target_reset_n <= 1'b1;
    repeat (8) @(posedge link_clk);
    target_reset_n <= 1'b0;
    repeat (8) @(posedge link_clk);
  endtask
endmodule
`default_nettype wire

// *** verif/spi_serial_programming_interface_tb_top.sv ***
// Self-checking bench for the serial programming port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module spi_serial_programming_interface_tb_top;
  import isp_pkg::*;
  logic sys_clk, link_clk, rst_n, sck, mosi, target_reset_n, miso, prog_enabled, prog_busy;
  int checks, n_mismatch, seed;
  logic [31:0] r;
  logic [7:0] d, d2, lk, pg;
  logic [9:0] ea;
  logic [5:0] idx;
  // ==========================================================================
  // Clocks; link base clock has an unrelated phase
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  // Short write times so polling runs stay brief
  isp_port #(.FLASH_WAIT(1000), .EE_WAIT(1000), .FUSE_WAIT(1000), .ERASE_WAIT(1000)) i_isp_port (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sck(sck),
    .mosi(mosi),
    .target_reset_n(target_reset_n),
    .miso(miso),
    .prog_enabled(prog_enabled),
    .prog_busy(prog_busy)
  );
  isp_prog_model i_isp_prog_model (
    .link_clk(link_clk),
    .sck(sck),
    .mosi(mosi),
    .target_reset_n(target_reset_n),
    .miso(miso)
  );
  // ==========================================================================
  // Helpers
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic frame(input logic [31:0] f);
    i_isp_prog_model.xfer(f, 32, r);
  endtask
  // Let the job start, then wait for it under a bound
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (8) @(posedge sys_clk);
    while (prog_busy !== 1'b0 && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20000) n_mismatch++;
  endtask
  function automatic logic [7:0] id_exp(input int s, input bit cal);
    return cal ? 8'(8'h80 + s) : (s == 3 ? 8'hFF : 8'(8'h11 * (s + 1)));
  endfunction
  // ==========================================================================
  // Main sequence
  initial begin
    seed = 24044;
    checks = 0;
    n_mismatch = 0;
    rst_n = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (100) @(posedge link_clk);
    frame({8'hAC, 3'b100, 5'($random(seed)), 16'h0});
    repeat (8) @(posedge sys_clk);
    `CHK("busy_refused", 1'b0, prog_busy)
    frame(32'hAC53A5A5);
    `CHK("enable_echo", OP_ENABLE2, r[15:8])
    repeat (8) @(posedge sys_clk);
    `CHK("enabled", 1'b1, prog_enabled)
    $display("test enable done");
    frame({8'hAC, 3'b100, 5'($random(seed)), 16'h0});
    wait_idle();
    ea = 10'($random(seed));
    frame({8'hA0, 6'h0, ea, 8'h00});
    `CHK("ee_erased", ERASED_BYTE, r[7:0])
    frame({8'h20, 2'b0, 14'($random(seed)), 8'h00});
    `CHK("fl_erased", ERASED_BYTE, r[7:0])
    $display("test erase done");
    d = 8'($random(seed));
    frame({8'hC0, 6'h0, ea, d});
    frame({8'hA0, 6'h0, ea, 8'h00});
    `CHK("ee_busy", ERASED_BYTE, r[7:0])
    wait_idle();
    frame({8'hA0, 6'h0, ea, 8'h00});
    `CHK("ee_data", d, r[7:0])
    $display("test eeprom done");
    idx = 6'($random(seed));
    pg = 8'($random(seed));
    d = 8'($random(seed));
    d2 = 8'($random(seed));
    frame({8'h40, 8'h00, 2'b0, idx, d});
    frame({8'h48, 8'h00, 2'b0, idx, d2});
    frame({8'h4C, 2'b0, pg[7:2], pg[1:0], 6'h0, 8'h00});
    frame({8'h20, 2'b0, pg, idx, 8'h00});
    `CHK("fl_busy", ERASED_BYTE, r[7:0])
    wait_idle();
    frame({8'h20, 2'b0, pg, idx, 8'h00});
    `CHK("fl_low", d, r[7:0])
    frame({8'h28, 2'b0, pg, idx, 8'h00});
    `CHK("fl_high", d2, r[7:0])
    $display("test page done");
    for (int k = 0; k < 2; k++) begin
      d = 8'($random(seed));
      frame({8'hAC, (k == 1) ? SUB_FUSE_HI : SUB_FUSE_LO, 8'h00, d});
      wait_idle();
      frame({(k == 1) ? OP_RD_LOCK : OP_RD_FUSE, (k == 1) ? SUB_RD_HI : 8'h00, 16'h0});
      `CHK("fuse", d, r[7:0])
    end
    // Lock bits only ever clear; erase left them all set
    lk = 8'hFF;
    for (int k = 0; k < 2; k++) begin
      d = 8'($random(seed));
      lk = lk & {2'b11, d[5:0]};
      frame({8'hAC, 8'hE0, 8'h00, 2'b11, d[5:0]});
      wait_idle();
      frame(32'h58000000);
      `CHK("lock", lk, r[7:0])
    end
    for (int s = 0; s < 4; s++) begin
      frame({8'h30, 8'h00, 6'h0, 2'(s), 8'h00});
      `CHK("signature", id_exp(s, 1'b0), r[7:0])
      frame({8'h38, 8'h00, 2'(s), 6'h0, 8'h00});
      `CHK("calibration", id_exp(s, 1'b1), r[7:0])
    end
    $display("test fuse lock id done");
    i_isp_prog_model.xfer(32'hFFF00000, 12, r);
    i_isp_prog_model.pulse_reset();
    `CHK("enable_cleared", 1'b0, prog_enabled)
    frame({16'hAC53, 16'($random(seed))});
    `CHK("retry_echo", OP_ENABLE2, r[15:8])
    repeat (8) @(posedge sys_clk);
    `CHK("re_enabled", 1'b1, prog_enabled)
    $display("test resync done");
    summarize();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    summarize();
  end
endmodule
`undef CHK
`default_nettype wire
